// ==== design/irq_tb_cfg.svh ====
// offsets, field positions, reset values and counts for the interrupt unit
// assumes a 32-bit apb slave with one register per aligned word
`ifndef IRQ_TB_CFG_SVH
`define IRQ_TB_CFG_SVH

// register byte addresses
`define OFF_PRESCALER     12'h000
`define OFF_TB_ZERO       12'h004
`define OFF_TB_ONE        12'h008
`define OFF_IRQ_ENABLE    12'h00C
`define OFF_IRQ_FLAG      12'h010
`define OFF_SRC_ENABLE    12'h014
`define OFF_SRC_FLAG      12'h018
`define OFF_CORE_STATUS   12'h01C

// time base control fields
`define TB_ON_BIT         7
`define TB_PERIOD_MSB     2
`define PSC_SEL_MSB       1
`define TB_BASE_EXP       8

// irq enable / flag bit positions
`define IRQ_CONV          0
`define IRQ_TB0           1
`define IRQ_TB1           2
`define IRQ_MF0           3
`define IRQ_MF1           4
`define IRQ_MF2           5
`define IRQ_GLOBAL        7

// source flag bit positions
`define SRC_TM0_A         0
`define SRC_TM0_P         1
`define SRC_TM1_A         2
`define SRC_TM1_P         3
`define SRC_EEPROM        4
`define SRC_LOW_VOLT      5

// reset values and the quarter counter value that gives the divided tick
`define RST_BYTE          8'h00
`define QUARTER_DIV       2'h3

`endif

// ==== design/irq_tb_pkg.sv ====
// types shared by the interrupt and time base unit
// assumes nothing beyond a systemverilog compiler
package irq_tb_pkg;

	// vector numbers handed to the core
	typedef enum logic [2:0] {
		VEC_CONV = 3'h0,
		VEC_TB0  = 3'h1,
		VEC_TB1  = 3'h2,
		VEC_MF0  = 3'h3,
		VEC_MF1  = 3'h4,
		VEC_MF2  = 3'h5
	} vector_e;

	// vector handshake states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK  = 2'b10
	} vec_state_e;

endpackage : irq_tb_pkg

// ==== design/irq_timebase_unit.sv ====
// interrupt request, vectoring and two time base generators
// assumes apb master on sys_clk_i, a core that takes vectors and returns,
// and peripheral event strobes one cycle wide, synchronous to sys_clk_i
// limitation: one vector stands at a time; others wait as flags
//
// The APB interface to the registers and the register addresses were left to the implementer.
`include "irq_tb_cfg.svh"

// How it works
// - source select: 00 core clock, 01 core clock over four, 1x low clock
// - prescaler bits 7..2 read zero, writes ignored
// - bit 7 of each time base control turns it on, resets off
// - time base zero times out every 2^(8+N) source clocks
// - time base one does the same with its own N field
// - conversion done sets its flag, servicing clears it
// - vector only with global, own and merged enables and room on stack
// - three merged interrupts built from timer, eeprom, low voltage
// - merged flag sets when any enabled member source flag is set
// - merged service clears merged flag and global enable only
// - eeprom write end sets flag, needs own and merged enable
// - low voltage or low sense input sets flag, hardware never clears
// - each timer gives compare A and P flags with enables into merged
// - any service clears global enable
// - any flag rising edge wakes device, enables ignored
// - flags stay set while disabled until serviced or cleared
// - only the program counter is pushed on vectoring
// - interrupt exit sets global enable, plain exit leaves it clear
// - each time base overflow sets its flag, service clears it
// - requests latch while disabled; no acknowledge while stack full
module irq_timebase_unit (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// peripheral events
	input  wire logic        low_clock_tick_i,
	input  wire logic        conversion_end_i,
	input  wire logic        eeprom_write_end_i,
	input  wire logic        supply_low_i,
	input  wire logic        external_voltage_sense_input_i,
	input  wire logic [1:0]  timer_module_match_a_i,
	input  wire logic [1:0]  timer_module_match_p_i,
	// processor core
	input  wire logic        stack_full_i,
	input  wire logic        vector_taken_i,
	input  wire logic        interrupt_exit_instruction_i,
	input  wire logic        subroutine_exit_instruction_i,
	output logic             vector_request_o,
	output logic      [2:0]  vector_number_o,
	output logic             push_pc_o,
	output logic             wake_up_o
);

	// software registers
	logic [1:0] prescaler_source_select_reg;
	logic       time_base_zero_on_reg;
	logic [2:0] time_base_zero_period_reg;
	logic       time_base_one_on_reg;
	logic [2:0] time_base_one_period_reg;
	logic [7:0] irq_enable_reg;
	logic [7:0] irq_flag_reg;
	logic [7:0] irq_flag_next;
	logic [5:0] src_enable_reg;
	logic [5:0] src_flag_reg;
	logic [5:0] src_flag_next;
	logic [7:0] flags_prev_reg;
	logic [1:0] quarter_reg;
	logic [14:0] tb0_count_reg;
	logic [14:0] tb1_count_reg;
	logic        psc_tick;
	logic        tb0_tick;
	logic        tb1_tick;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic [5:0]  pending;
	logic [5:0]  grant;
	logic [7:0]  wdata;
	logic        global_irq_enable;
	irq_tb_pkg::vec_state_e state_reg;
	logic [2:0]  vec_reg;
	logic [7:0]  irq_enable_next;
	logic        service;

	// apb decode: every access ends in one cycle, unmapped gives slverr
	// pstrb_i[0] guards writes: only lane 0 carries bits, so a write
	// with upper strobes alone is dropped
	assign wdata   = pwdata_i[7:0];
	assign wr_en   = psel_i && penable_i && pwrite_i && pstrb_i[0];
	assign rd_en   = psel_i && penable_i && !pwrite_i;
	assign addr_ok = (paddr_i[1:0] == 2'h0) &&
	                 (paddr_i <= `OFF_CORE_STATUS);
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && !addr_ok;
	assign global_irq_enable = irq_enable_reg[`IRQ_GLOBAL];
	// a vector counts as serviced on the edge at which the core takes it
	assign service = (state_reg == irq_tb_pkg::ST_ACK) && vector_taken_i;

	// prescaler tick in sys_clk_i cycles
	// the quarter counter free-runs, so after a select change the first
	// divided tick comes within four cycles
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			quarter_reg <= 2'h0;
		end else begin
			quarter_reg <= quarter_reg + 2'h1;
		end
	end

	// source clock is an enable pulse, so the dividers stay on one clock
	always_comb begin
		if (prescaler_source_select_reg[1]) begin
			psc_tick = low_clock_tick_i;
		end else if (prescaler_source_select_reg[0]) begin
			psc_tick = (quarter_reg == `QUARTER_DIV);
		end else begin
			psc_tick = 1'b1;
		end
	end

	// time base zero divider, held clear while off
	// clearing it while off makes the first period after switch-on full
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			tb0_count_reg <= 15'h0000;
		end else if (!time_base_zero_on_reg) begin
			tb0_count_reg <= 15'h0000;
		end else if (psc_tick) begin
			tb0_count_reg <= tb0_count_reg + 15'h0001;
		end
	end

	// time base one divider, held clear while off
	// same as time base zero, on its own enable
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			tb1_count_reg <= 15'h0000;
		end else if (!time_base_one_on_reg) begin
			tb1_count_reg <= 15'h0000;
		end else if (psc_tick) begin
			tb1_count_reg <= tb1_count_reg + 15'h0001;
		end
	end

	// time-out when the low 8+N bits are all ones on a source tick
	// the tick lands on the last source tick of a period, so the divider
	// wraps by itself and the next period starts from zero
	always_comb begin
		tb0_tick = time_base_zero_on_reg && psc_tick &&
			(&(tb0_count_reg | ~(15'h7FFF >>
			(3'h7 - time_base_zero_period_reg))));
		tb1_tick = time_base_one_on_reg && psc_tick &&
			(&(tb1_count_reg | ~(15'h7FFF >>
			(3'h7 - time_base_one_period_reg))));
	end

	// prescaler and time base control registers
	// a new period field applies at once; the running count is kept, so
	// the first time-out after the change may come early or late
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			prescaler_source_select_reg <= 2'h0;
			time_base_zero_on_reg       <= 1'b0;
			time_base_zero_period_reg   <= 3'h0;
			time_base_one_on_reg        <= 1'b0;
			time_base_one_period_reg    <= 3'h0;
		end else if (wr_en) begin
			case (paddr_i)
				`OFF_PRESCALER: begin
					prescaler_source_select_reg <= wdata[1:0];
				end
				`OFF_TB_ZERO: begin
					time_base_zero_on_reg     <= wdata[`TB_ON_BIT];
					time_base_zero_period_reg <= wdata[2:0];
				end
				`OFF_TB_ONE: begin
					time_base_one_on_reg     <= wdata[`TB_ON_BIT];
					time_base_one_period_reg <= wdata[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	// source enables
	// member enables gate which sources feed their merged flag
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			src_enable_reg <= 6'h00;
		end else if (wr_en && paddr_i == `OFF_SRC_ENABLE) begin
			src_enable_reg <= wdata[5:0];
		end
	end

	// source flags: hardware set beats a software clear in the same cycle
	// a level on the supply or sense input keeps setting the low voltage
	// flag; software can clear it only once the level has gone
	always_comb begin
		src_flag_next = src_flag_reg;
		if (wr_en && paddr_i == `OFF_SRC_FLAG) begin
			src_flag_next = wdata[5:0];
		end
		src_flag_next[`SRC_TM0_A] |= timer_module_match_a_i[0];
		src_flag_next[`SRC_TM0_P] |= timer_module_match_p_i[0];
		src_flag_next[`SRC_TM1_A] |= timer_module_match_a_i[1];
		src_flag_next[`SRC_TM1_P] |= timer_module_match_p_i[1];
		src_flag_next[`SRC_EEPROM] |= eeprom_write_end_i;
		src_flag_next[`SRC_LOW_VOLT] |= supply_low_i ||
			external_voltage_sense_input_i;
	end

	// source flags are never touched by servicing
	// hardware only ever sets them, so the low voltage flag sticks
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			src_flag_reg <= 6'h00;
		end else begin
			src_flag_reg <= src_flag_next;
		end
	end

	// pending requests, enabled and not blocked by a full stack
	// a full stack gates the whole set, so it holds back every vector,
	// not only the one that would have been taken
	always_comb begin
		pending = irq_flag_reg[5:0] & irq_enable_reg[5:0] &
			{6{global_irq_enable && !stack_full_i}};
		grant = pending & (~pending + 6'h01); // lowest bit first
	end

	// top-level flags: set by events, cleared by service or software
	always_comb begin
		irq_flag_next = irq_flag_reg;
		if (wr_en && paddr_i == `OFF_IRQ_FLAG) begin
			irq_flag_next = {2'h0, wdata[5:0]};
		end
		if (state_reg == irq_tb_pkg::ST_ACK && vector_taken_i) begin
			irq_flag_next[vec_reg] = 1'b0;
		end
		irq_flag_next[`IRQ_CONV] |= conversion_end_i;
		irq_flag_next[`IRQ_TB0]  |= tb0_tick;
		irq_flag_next[`IRQ_TB1]  |= tb1_tick;
		// a merged flag re-sets while an enabled member stays set, so
		// software clears the member before returning
		// merged groups: timer 0, timer 1, eeprom plus low voltage
		irq_flag_next[`IRQ_MF0] |= |(src_flag_reg[1:0] &
			src_enable_reg[1:0]);
		irq_flag_next[`IRQ_MF1] |= |(src_flag_reg[3:2] &
			src_enable_reg[3:2]);
		irq_flag_next[`IRQ_MF2] |= |(src_flag_reg[5:4] &
			src_enable_reg[5:4]);
	end

	// flags hold until serviced or cleared, whatever the enables
	// a request seen while disabled waits here for the global enable
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_flag_reg <= `RST_BYTE;
		end else begin
			irq_flag_reg <= irq_flag_next;
		end
	end

	// enables: software owns the source bits; the global bit also follows
	// service and exit, and a service clear beats both of them
	always_comb begin
		irq_enable_next = irq_enable_reg;
		if (wr_en && paddr_i == `OFF_IRQ_ENABLE) begin
			irq_enable_next = {wdata[7], 1'b0, wdata[5:0]};
		end
		if (interrupt_exit_instruction_i) begin
			irq_enable_next[`IRQ_GLOBAL] = 1'b1;
		end
		if (service) begin
			irq_enable_next[`IRQ_GLOBAL] = 1'b0;
		end
		// plain subroutine exit leaves the global enable alone
	end

	// a source enable written in the service cycle is kept, not dropped
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_enable_reg <= `RST_BYTE;
		end else begin
			irq_enable_reg <= irq_enable_next;
		end
	end

	// vector handshake: request held until the core takes it
	// number and request stand until the take; a flag that software
	// clears meanwhile still gets its vector, and the service then
	// clears it once more, which is harmless
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= irq_tb_pkg::ST_IDLE;
			vec_reg   <= 3'h0;
		end else begin
			case (state_reg)
				irq_tb_pkg::ST_IDLE: begin
					if (|grant) begin
						state_reg <= irq_tb_pkg::ST_ACK;
						for (int i = 0; i < 6; i++) begin
							if (grant[i]) begin
								vec_reg <= 3'(i);
							end
						end
					end
				end
				irq_tb_pkg::ST_ACK: begin
					if (vector_taken_i) begin
						state_reg <= irq_tb_pkg::ST_IDLE;
					end
				end
				// an illegal code falls back to idle instead of locking up
				default: begin
					state_reg <= irq_tb_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// the core pushes only its program counter on the taken edge
	// the push is combinational so the core sees it in the take cycle
	assign vector_request_o = (state_reg == irq_tb_pkg::ST_ACK);
	assign vector_number_o  = vec_reg;
	assign push_pc_o = vector_request_o && vector_taken_i;

	// rising edge of any flag wakes the core; enables play no part
	// limitation: a flag already high cannot rise, so a preset flag
	// keeps its source from waking the core
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			flags_prev_reg <= 8'h00;
			wake_up_o      <= 1'b0;
		end else begin
			flags_prev_reg <= {src_flag_reg, irq_flag_reg[5:4]};
			wake_up_o <= |({src_flag_reg, irq_flag_reg[5:4]} &
				~flags_prev_reg) ||
				|(irq_flag_next[3:0] & ~irq_flag_reg[3:0]);
		end
	end

	// read data, registered; reserved bits read zero
	// loaded in the setup cycle so it stands through the access phase;
	// a flag that sets during the access shows on the next read
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			case (paddr_i)
				`OFF_PRESCALER: prdata_o <= {30'h0, prescaler_source_select_reg};
				`OFF_TB_ZERO: prdata_o <= {24'h0, time_base_zero_on_reg,
					4'h0, time_base_zero_period_reg};
				`OFF_TB_ONE: prdata_o <= {24'h0, time_base_one_on_reg,
					4'h0, time_base_one_period_reg};
				`OFF_IRQ_ENABLE: prdata_o <= {24'h0, irq_enable_reg};
				`OFF_IRQ_FLAG: prdata_o <= {24'h0, irq_flag_reg};
				`OFF_SRC_ENABLE: prdata_o <= {26'h0, src_enable_reg};
				`OFF_SRC_FLAG: prdata_o <= {26'h0, src_flag_reg};
				`OFF_CORE_STATUS: prdata_o <= {28'h0, stack_full_i,
					vec_reg};
				default: prdata_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule : irq_timebase_unit

// ==== tb/irq_core_model.sv ====
// core model: takes each vector after delay_i cycles, returns later
// assumes the unit holds its request until the take is seen
module irq_core_model (
	// clock, reset and bench commands
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	input  wire logic [3:0] delay_i,
	input  wire logic       plain_ret_i,
	// vector handshake
	input  wire logic       req_i,
	output logic            taken_o,
	output logic            interrupt_exit_instruction_o,
	output logic            ret_o
);
	logic [3:0] wait_reg;
	logic [2:0] ret_reg;

	// one service at a time, never a nested call inside it
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wait_reg <= 4'h0;
			ret_reg <= 3'h0;
			taken_o <= 1'b0;
			interrupt_exit_instruction_o <= 1'b0;
			ret_o <= 1'b0;
		end else begin
			taken_o <= 1'b0;
			interrupt_exit_instruction_o <= ret_reg == 3'h1 && !plain_ret_i;
			ret_o <= ret_reg == 3'h1 && plain_ret_i;
			if (ret_reg != 3'h0)
				ret_reg <= ret_reg - 3'h1;
			if (req_i && !taken_o) begin
				wait_reg <= wait_reg + 4'h1;
				if (wait_reg >= delay_i) begin
					taken_o <= 1'b1;
					wait_reg <= 4'h0;
					ret_reg <= 3'h4;
				end
			end
		end
	end
endmodule : irq_core_model

// ==== tb/irq_timebase_unit_chk.sv ====
// checker: vector handshake and read-back of control registers
// assumes bind onto irq_timebase_unit, one clock domain
`include "irq_tb_cfg.svh"
module irq_timebase_unit_chk (
	// clock, reset and apb
	input wire logic        sys_clk_i,
	input wire logic        reset_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	// core side
	input wire logic        stack_full_i,
	input wire logic        vector_taken_i,
	input wire logic        vector_request_o,
	input wire logic [2:0]  vector_number_o,
	input wire logic        push_pc_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	logic rd;

	// read access phase, where read data is valid
	assign rd = psel_i && penable_i && !pwrite_i;

	property p_push;
		push_pc_o == (vector_request_o && vector_taken_i);
	endproperty
	a_push: assert property (p_push)
		else $error("pc push mismatch");
	property p_hold;
		vector_request_o && !vector_taken_i |=>
			vector_request_o && $stable(vector_number_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("request dropped before take");
	property p_drop;
		vector_request_o && vector_taken_i |=> !vector_request_o [*2];
	endproperty
	a_drop: assert property (p_drop)
		else $error("request again before enable");
	property p_full;
		$rose(vector_request_o) |-> !$past(stack_full_i);
	endproperty
	a_full: assert property (p_full)
		else $error("request while stack full");
	property p_range;
		vector_request_o |-> vector_number_o <= 3'h5;
	endproperty
	a_range: assert property (p_range)
		else $error("vector number out of range");
	property p_psc;
		rd && paddr_i == `OFF_PRESCALER |-> prdata_o[31:2] == 30'h0;
	endproperty
	a_psc: assert property (p_psc)
		else $error("prescaler spare bits set");
	property p_tb0;
		rd && paddr_i == `OFF_TB_ZERO |->
			prdata_o[31:8] == 24'h0 && prdata_o[6:3] == 4'h0;
	endproperty
	a_tb0: assert property (p_tb0)
		else $error("time base zero spare bits set");
	property p_tb1;
		rd && paddr_i == `OFF_TB_ONE |->
			prdata_o[31:8] == 24'h0 && prdata_o[6:3] == 4'h0;
	endproperty
	a_tb1: assert property (p_tb1)
		else $error("time base one spare bits set");
endmodule : irq_timebase_unit_chk

bind irq_timebase_unit irq_timebase_unit_chk irq_timebase_unit_chk_i (
	.sys_clk_i        (sys_clk_i),
	.reset_i          (reset_i),
	.psel_i           (psel_i),
	.penable_i        (penable_i),
	.pwrite_i         (pwrite_i),
	.paddr_i          (paddr_i),
	.prdata_o         (prdata_o),
	.stack_full_i     (stack_full_i),
	.vector_taken_i   (vector_taken_i),
	.vector_request_o (vector_request_o),
	.vector_number_o  (vector_number_o),
	.push_pc_o        (push_pc_o)
);

// ==== tb/irq_timebase_unit_test.sv ====
// bench: apb driver and events note expectations, a monitor compares
// assumes an apb slave that may stall and the core model taking vectors
`include "irq_tb_cfg.svh"
module irq_timebase_unit_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_i, reset_i, psel_i, penable_i, pwrite_i;
	logic [11:0] paddr_i, a;
	logic [31:0] pwdata_i, prdata_o, r;
	logic [3:0]  pstrb_i, delay;
	logic        pready_o, pslverr_o, low_clock_tick_i, conversion_end_i;
	logic        eeprom_write_end_i, supply_low_i, plain_ret, stack_full_i;
	logic        external_voltage_sense_input_i, vector_taken_i, push_pc_o;
	logic [1:0]  timer_module_match_a_i, timer_module_match_p_i;
	logic        interrupt_exit_instruction_i, subroutine_exit_instruction_i;
	logic        vector_request_o, wake_up_o;
	logic [2:0]  vector_number_o, tick;
	logic [32:0] rd_q[$];
	logic [2:0]  vec_q[$];
	int          n_fail, num_checks, wakes, cyc;

	irq_timebase_unit irq_timebase_unit_i (.*);
	irq_core_model irq_core_model_i (.sys_clk_i, .reset_i, .delay_i(delay),
		.plain_ret_i(plain_ret), .req_i(vector_request_o),
		.taken_o(vector_taken_i), .interrupt_exit_instruction_o(interrupt_exit_instruction_i),
		.ret_o(subroutine_exit_instruction_i));

	// clock at 250 MHz
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	// low-speed tick every eighth cycle
	always @(posedge sys_clk_i) begin
		tick <= tick + 3'h1;
		low_clock_tick_i <= tick == 3'h7;
	end
	// each read and each taken vector against the oldest note
	always @(posedge sys_clk_i) begin
		if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
			chk("read", rd_q.pop_front(), {pslverr_o, prdata_o});
		if (push_pc_o === 1'b1)
			chk("vector", vec_q.size() ? {30'h0, vec_q.pop_front()}
				: 33'h1_0000_0000, {30'h0, vector_number_o});
		if (wake_up_o === 1'b1)
			wakes++;
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		end_of_test();
	end

	task automatic chk(input string s, input logic [32:0] e, g);
		num_checks++;
		if (e !== g) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// setup, then access until pready is sampled high, then one idle edge
	task automatic apb(input logic w, input logic [11:0] ad, input int d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= ad;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		cyc = 0;
		do begin
			@(posedge sys_clk_i);
			cyc++;
		end while (pready_o !== 1'b1 && cyc < 20);
		if (cyc >= 20) begin
			chk("pready", 33'h1, 33'h0);
			end_of_test();
		end
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : apb
	task automatic rd(input logic [11:0] ad, input logic [32:0] e);
		rd_q.push_back(e);
		apb(1'b0, ad, 0);
	endtask : rd
	// event pulses: conv, eeprom, supply, sense, match a, match p
	task automatic ev(input logic [7:0] e);
		{conversion_end_i, eeprom_write_end_i, supply_low_i,
			external_voltage_sense_input_i, timer_module_match_a_i,
			timer_module_match_p_i} <= e;
		@(posedge sys_clk_i);
		{conversion_end_i, eeprom_write_end_i, supply_low_i,
			external_voltage_sense_input_i, timer_module_match_a_i,
			timer_module_match_p_i} <= 8'h00;
	endtask : ev
	// wait until every noted vector was taken, plus the return
	task automatic drain();
		for (cyc = 0; vec_q.size() != 0 && cyc < 300; cyc++)
			@(posedge sys_clk_i);
		if (cyc >= 300) begin
			chk("drain", 33'h0, 33'h1);
			end_of_test();
		end
		repeat (8) @(posedge sys_clk_i);
	endtask : drain
	task automatic end_of_test();
		if (n_fail == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	initial begin
		reset_i = 1'b1;
		{psel_i, penable_i, pwrite_i, stack_full_i, plain_ret, tick} = '0;
		{paddr_i, pwdata_i, delay, low_clock_tick_i} = '0;
		{conversion_end_i, eeprom_write_end_i, supply_low_i,
			external_voltage_sense_input_i, timer_module_match_a_i,
			timer_module_match_p_i} = '0;
		pstrb_i = 4'hF;
		r = $urandom(45);
		repeat (20) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		@(posedge sys_clk_i);
		// reset values, writable bits, unmapped place
		for (int i = 0; i < 3; i++) begin
			rd(12'(4 * i), 33'h0);
			r = $urandom();
			apb(1'b1, 12'(4 * i), r);
			r &= i ? 32'h0000_0087 : 32'h0000_0003;
			rd(12'(4 * i), {1'b0, r});
			apb(1'b1, 12'(4 * i), 0);
		end
		rd(12'h020, 33'h1_0000_0000);
		// conversion vector; the interrupt exit sets the enable again
		apb(1'b1, `OFF_IRQ_ENABLE, 32'h0000_0081);
		wakes = 0;
		delay <= 4'($urandom_range(7));
		vec_q.push_back(irq_tb_pkg::VEC_CONV);
		ev(8'h80);
		drain();
		chk("wake", 33'h1, 33'(wakes));
		rd(`OFF_IRQ_FLAG, 33'h0);
		rd(`OFF_IRQ_ENABLE, 33'h81);
		// flags set with enables off wake once; preset flags stay quiet
		apb(1'b1, `OFF_IRQ_ENABLE, 0);
		wakes = 0;
		apb(1'b1, `OFF_IRQ_FLAG, 32'h0000_0006);
		apb(1'b1, `OFF_IRQ_FLAG, 32'h0000_0006);
		repeat (3) @(posedge sys_clk_i);
		chk("wake", 33'h1, 33'(wakes));
		// a full stack holds both back, then the fixed order serves them
		stack_full_i <= 1'b1;
		apb(1'b1, `OFF_IRQ_ENABLE, 32'h0000_0086);
		repeat (10) @(posedge sys_clk_i);
		delay <= 4'($urandom_range(7));
		vec_q.push_back(irq_tb_pkg::VEC_TB0);
		vec_q.push_back(irq_tb_pkg::VEC_TB1);
		stack_full_i <= 1'b0;
		drain();
		rd(`OFF_IRQ_FLAG, 33'h0);
		// merged service keeps the source flag; plain exit keeps enable off
		plain_ret <= 1'b1;
		apb(1'b1, `OFF_SRC_ENABLE, 32'h0000_003F);
		apb(1'b1, `OFF_IRQ_ENABLE, 32'h0000_00A0);
		vec_q.push_back(irq_tb_pkg::VEC_MF2);
		ev(8'h20);
		drain();
		rd(`OFF_SRC_FLAG, 33'h20);
		rd(`OFF_IRQ_ENABLE, 33'h20);
		// every member source sets its own flag and its merged flag
		apb(1'b1, `OFF_SRC_FLAG, 0);
		ev(8'h5F);
		rd(`OFF_SRC_FLAG, 33'h3F);
		rd(`OFF_IRQ_FLAG, 33'h38);
		apb(1'b1, `OFF_SRC_ENABLE, 0);
		apb(1'b1, `OFF_SRC_FLAG, 0);
		// time-outs: 256, 4 x 512 and 8 x 256 cycles after switching on
		for (int i = 0; i < 3; i++) begin
			a = i == 1 ? `OFF_TB_ONE : `OFF_TB_ZERO;
			apb(1'b1, `OFF_PRESCALER, i);
			apb(1'b1, `OFF_IRQ_FLAG, 0);
			apb(1'b1, a, i == 1 ? 32'h0000_0081 : 32'h0000_0080);
			repeat (i ? 2032 : 240) @(posedge sys_clk_i);
			rd(`OFF_IRQ_FLAG, 33'h0);
			repeat (28) @(posedge sys_clk_i);
			rd(`OFF_IRQ_FLAG, i == 1 ? 33'h4 : 33'h2);
			apb(1'b1, a, 0);
		end
		end_of_test();
	end
endmodule : irq_timebase_unit_test
